/* pkg/brsm_cfg.svh */
// Constants of the braking ramp safety monitor: timing, widths, limits.
// Assumes a 25 MHz system clock and a 4 ms safety monitoring cycle.
`ifndef BRSM_CFG_SVH
`define BRSM_CFG_SVH

`define BRSM_CLK_KHZ 25000
`define BRSM_MC_MS 4
`define BRSM_MC_CLKS (`BRSM_MC_MS * `BRSM_CLK_KHZ)
`define BRSM_MIN_DELAY_MS 10
`define BRSM_MIN_DELAY_MC 2
`define BRSM_MIN_DELAY_CYC_A ((`BRSM_MIN_DELAY_MS + `BRSM_MC_MS - 1) / `BRSM_MC_MS)
`define BRSM_MIN_DELAY_CYC \
    ((`BRSM_MIN_DELAY_CYC_A > `BRSM_MIN_DELAY_MC) ? `BRSM_MIN_DELAY_CYC_A : `BRSM_MIN_DELAY_MC)
`define BRSM_RAMP_DELAY_DEF_MS 16'h00FA
`define BRSM_SPD_W 16
`define BRSM_FRAC_W 8
`define BRSM_DIV_W 26

`endif

/* pkg/brsm_pkg.sv */
// Types of the braking ramp safety monitor.
// Assumes brsm_cfg.svh for widths.
`include "brsm_cfg.svh"

package brsm_pkg;

    typedef enum logic [2:0] {
        BRSM_IDLE = 3'b000,
        BRSM_BRAKE = 3'b001,
        BRSM_TORQUE_OFF = 3'b011,
        BRSM_SAFE_OP = 3'b010,
        BRSM_LIMITED = 3'b110
    } brsm_state_t;

    typedef enum logic [1:0] {
        BRSM_KIND_CS = 2'b00,
        BRSM_KIND_OS = 2'b01,
        BRSM_KIND_LS = 2'b10
    } brsm_kind_t;

    typedef struct packed {
        logic controlled_stop;
        logic operating_stop;
        logic limited_speed;
        logic failsafe_input;
    } brsm_sel_t;

    typedef struct packed {
        logic [15:0] accel_speed_tolerance;
        logic [15:0] accel_shutdown_speed;
        logic [15:0] ramp_delay_time;
        logic [15:0] ramp_monitor_time;
        logic [15:0] ramp_reference_velocity;
        logic [15:0] torque_off_shutdown_speed;
        logic [15:0] controlled_stop_delay;
        logic [15:0] operating_stop_delay;
        logic [15:0] new_speed_limit;
    } brsm_cfg_t;

endpackage

/* logic/brsm_cycle_timer.sv */
// Monitoring cycle divider: one-cycle tick every CYCLE_CLKS clocks.
// Assumes a single free-running system clock.
`timescale 1ns/1ps

module brsm_cycle_timer #(
    parameter int CYCLE_CLKS = 100000
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    output logic tick
);

    logic [16:0] cnt;
    wire wrap = (cnt == 17'(CYCLE_CLKS - 1));

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 17'h0_0000;
            tick <= 1'b0;
        end else begin
            cnt <= wrap ? 17'h0_0000 : cnt + 17'h0_0001;
            tick <= wrap;
        end
    end

endmodule

/* logic/brsm_ramp_limit.sv */
// Descending ramp limit, 16.8 fixed point, falling by ref*cycle/time per tick.
// Assumes start arrives well before the next tick; division takes 26 clocks.
`timescale 1ns/1ps

module brsm_ramp_limit (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic start,
    input wire logic tick,
    input wire logic [15:0] ref_vel,
    input wire logic [15:0] mon_time,
    output logic [23:0] limit
);

    logic [25:0] quo;
    logic [16:0] rem;
    logic [4:0] iter;
    logic busy;

    // Restoring divider step
    wire [16:0] rem_sh = {rem[15:0], quo[25]};
    wire ge = (rem_sh >= {1'b0, mon_time});
    wire [16:0] next_rem = ge ? (rem_sh - {1'b0, mon_time}) : rem_sh;
    wire [25:0] lim_w = {2'b00, limit};
    wire [23:0] next_limit = (lim_w > quo) ? 24'(lim_w - quo) : 24'h00_0000;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            quo <= 26'h000_0000;
            rem <= 17'h0_0000;
            iter <= 5'h00;
            busy <= 1'b0;
            limit <= 24'h00_0000;
        end else if (start) begin
            quo <= {ref_vel, 2'b00, 8'h00};
            rem <= 17'h0_0000;
            iter <= 5'h19;
            busy <= 1'b1;
            limit <= {ref_vel, 8'h00};
        end else if (busy) begin
            rem <= next_rem;
            quo <= {quo[24:0], ge};
            iter <= iter - 5'h01;
            busy <= (iter != 5'h00);
        end else if (tick) begin
            limit <= next_limit;
        end
    end

endmodule

/* logic/brsm_top.sv */
// Braking ramp safety monitor: stop sequencing, acceleration and ramp monitors.
// Assumes inputs synchronous to clk_sys; speed is an unsigned magnitude.
`timescale 1ns/1ps
`include "brsm_cfg.svh"

module brsm_top #(
    parameter int MC_CLKS = `BRSM_MC_CLKS
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire brsm_pkg::brsm_sel_t sel,
    input wire logic sel_from_diag,
    input wire brsm_pkg::brsm_cfg_t cfg,
    input wire logic [15:0] speed_actual,
    input wire logic msg_ack,
    output logic torque_off,
    output logic safe_operating_stop,
    output logic limited_speed,
    output logic [15:0] speed_limit_out,
    output logic setpoint_zero,
    output logic fast_stop_ramp,
    output logic accel_monitor,
    output logic brake_ramp_monitor,
    output logic limit_exceeded_message,
    output logic [15:0] accel_ceiling
);

    // ------------------------------------------------------------
    // Cycle rounding
    // ------------------------------------------------------------
    function automatic logic [15:0] ms_to_cyc(input logic [15:0] ms);
        logic [16:0] sum;
        sum = {1'b0, ms} + 17'h0_0002;
        return sum[16:1] >> 1;
    endfunction

    // ------------------------------------------------------------
    // Monitoring cycle tick and ramp limit
    // ------------------------------------------------------------
    logic tick;
    logic ramp_start;
    logic [23:0] ramp_limit;

    brsm_cycle_timer #(
        .CYCLE_CLKS(MC_CLKS)
    ) u_timer (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .tick(tick)
    );

    brsm_ramp_limit u_ramp (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .start(ramp_start),
        .tick(tick),
        .ref_vel(cfg.ramp_reference_velocity),
        .mon_time(cfg.ramp_monitor_time),
        .limit(ramp_limit)
    );

    // ------------------------------------------------------------
    // Selection decode
    // ------------------------------------------------------------
    brsm_pkg::brsm_state_t state;
    brsm_pkg::brsm_state_t next_state;
    brsm_pkg::brsm_kind_t kind;
    brsm_pkg::brsm_kind_t next_kind;
    logic [15:0] cyc;
    logic [16:0] ceiling;

    // Diagnostic telegrams select nothing
    wire [3:0] sel_ok = sel_from_diag ? 4'h0 : sel;
    wire sel_cs = sel_ok[3] | sel_ok[0];
    wire sel_os = sel_ok[2];
    wire sel_ls = sel_ok[1];
    wire any_sel = sel_cs | sel_os | sel_ls;
    wire cs_delay_zero = (cfg.controlled_stop_delay == 16'h0000);
    wire fi_direct = sel_ok[0] & cs_delay_zero;

    // ------------------------------------------------------------
    // Delay counts in monitoring cycles
    // ------------------------------------------------------------
    wire [15:0] delay_rnd = ms_to_cyc(cfg.ramp_delay_time);
    wire [15:0] min_delay = 16'(`BRSM_MIN_DELAY_CYC);
    wire [15:0] ramp_delay_cyc = (delay_rnd < min_delay) ? min_delay : delay_rnd;
    wire [15:0] cs_delay_cyc = ms_to_cyc(cfg.controlled_stop_delay);
    wire [15:0] os_delay_cyc = ms_to_cyc(cfg.operating_stop_delay);

    // ------------------------------------------------------------
    // Monitors, evaluated on the sampled speed each tick
    // ------------------------------------------------------------
    wire [16:0] spd = {1'b0, speed_actual};
    wire [16:0] spd_tol = spd + {1'b0, cfg.accel_speed_tolerance};
    wire braking = (state == brsm_pkg::BRSM_BRAKE);
    wire acc_kind = (kind != brsm_pkg::BRSM_KIND_LS);
    wire acc_run = braking & acc_kind & accel_monitor;
    wire acc_viol = acc_run & (spd > ceiling);
    wire acc_below = (speed_actual < cfg.accel_shutdown_speed);
    wire [16:0] next_ceiling = (spd_tol < ceiling) ? spd_tol : ceiling;
    wire [16:0] cyc_el = {1'b0, cyc} + 17'h0_0001;
    wire ramp_due = braking & acc_kind & (cyc_el >= {1'b0, ramp_delay_cyc});
    wire ramp_viol = ramp_due & ({speed_actual, 8'h00} > ramp_limit);
    wire violation = tick & (acc_viol | ramp_viol);

    // End of the braking phase per stop kind
    wire cs_end = (speed_actual < cfg.torque_off_shutdown_speed) | (cyc_el >= {1'b0, cs_delay_cyc});
    wire os_end = (cyc_el >= {1'b0, os_delay_cyc});
    wire ls_end = (speed_actual <= cfg.new_speed_limit);

    // ------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_kind = kind;
        if (violation) begin
            next_state = brsm_pkg::BRSM_TORQUE_OFF;
        end else if (tick) begin
            unique case (state)
                brsm_pkg::BRSM_IDLE: begin
                    if (fi_direct) begin
                        next_state = brsm_pkg::BRSM_TORQUE_OFF;
                    end else if (any_sel) begin
                        next_state = brsm_pkg::BRSM_BRAKE;
                        if (sel_cs) begin
                            next_kind = brsm_pkg::BRSM_KIND_CS;
                        end else if (sel_os) begin
                            next_kind = brsm_pkg::BRSM_KIND_OS;
                        end else begin
                            next_kind = brsm_pkg::BRSM_KIND_LS;
                        end
                    end
                end
                brsm_pkg::BRSM_BRAKE: begin
                    unique case (kind)
                        brsm_pkg::BRSM_KIND_CS: begin
                            if (cs_end) begin
                                next_state = brsm_pkg::BRSM_TORQUE_OFF;
                            end
                        end
                        brsm_pkg::BRSM_KIND_OS: begin
                            if (os_end) begin
                                next_state = brsm_pkg::BRSM_SAFE_OP;
                            end
                        end
                        default: begin
                            if (ls_end) begin
                                next_state = brsm_pkg::BRSM_LIMITED;
                            end
                        end
                    endcase
                end
                brsm_pkg::BRSM_TORQUE_OFF: begin
                    if (!any_sel && !limit_exceeded_message) begin
                        next_state = brsm_pkg::BRSM_IDLE;
                    end
                end
                brsm_pkg::BRSM_SAFE_OP: begin
                    if (!sel_os) begin
                        next_state = brsm_pkg::BRSM_IDLE;
                    end
                end
                brsm_pkg::BRSM_LIMITED: begin
                    if (!sel_ls) begin
                        next_state = brsm_pkg::BRSM_IDLE;
                    end
                end
                default: begin
                    next_state = brsm_pkg::BRSM_TORQUE_OFF;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Derived controls
    // ------------------------------------------------------------
    wire enter_brake = tick & (state == brsm_pkg::BRSM_IDLE) & (next_state == brsm_pkg::BRSM_BRAKE);
    wire stopping = (next_state == brsm_pkg::BRSM_BRAKE) & (next_kind != brsm_pkg::BRSM_KIND_LS);
    wire next_to = (next_state == brsm_pkg::BRSM_TORQUE_OFF);
    wire next_sz = stopping | next_to | (next_state == brsm_pkg::BRSM_SAFE_OP);
    wire next_acc = enter_brake ? (next_kind != brsm_pkg::BRSM_KIND_LS)
                  : (accel_monitor & (next_state == brsm_pkg::BRSM_BRAKE) & ~(tick & acc_below) & ~violation);
    wire next_msg = violation | (limit_exceeded_message & ~msg_ack);
    wire [15:0] next_cyc = enter_brake ? 16'h0000
                         : ((tick & braking & (cyc != 16'hFFFF)) ? cyc + 16'h0001 : cyc);
    wire [16:0] ceil_upd = enter_brake ? spd_tol : ((tick & acc_run) ? next_ceiling : ceiling);
    wire next_rm = stopping & ~enter_brake & (next_cyc >= ramp_delay_cyc);
    wire [15:0] next_lim = (next_state == brsm_pkg::BRSM_LIMITED) ? cfg.new_speed_limit : speed_limit_out;

    assign ramp_start = enter_brake;

    // ------------------------------------------------------------
    // State and monitor registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= brsm_pkg::BRSM_IDLE;
            kind <= brsm_pkg::BRSM_KIND_CS;
            cyc <= 16'h0000;
            ceiling <= 17'h1_FFFF;
        end else begin
            state <= next_state;
            kind <= next_kind;
            cyc <= next_cyc;
            ceiling <= ceil_upd;
        end
    end

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            torque_off <= 1'b0;
            safe_operating_stop <= 1'b0;
            limited_speed <= 1'b0;
            speed_limit_out <= 16'h0000;
            setpoint_zero <= 1'b0;
            fast_stop_ramp <= 1'b0;
            accel_monitor <= 1'b0;
            brake_ramp_monitor <= 1'b0;
            limit_exceeded_message <= 1'b0;
            accel_ceiling <= 16'h0000;
        end else begin
            torque_off <= next_to;
            safe_operating_stop <= (next_state == brsm_pkg::BRSM_SAFE_OP);
            limited_speed <= (next_state == brsm_pkg::BRSM_LIMITED);
            speed_limit_out <= next_lim;
            setpoint_zero <= next_sz;
            fast_stop_ramp <= stopping;
            accel_monitor <= next_acc;
            brake_ramp_monitor <= next_rm;
            limit_exceeded_message <= next_msg;
            accel_ceiling <= ceil_upd[16] ? 16'hFFFF : ceil_upd[15:0];
        end
    end

endmodule

/* tb/brsm_chk.sv */
// Checker of the braking ramp safety monitor, bound to its top.
// Assumes one clock clk_sys and async active low rst_n.
`timescale 1ns/1ps

module brsm_chk #(
    parameter int MC_CLKS = 100000
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire brsm_pkg::brsm_sel_t sel,
    input wire logic sel_from_diag,
    input wire brsm_pkg::brsm_cfg_t cfg,
    input wire logic [15:0] speed_actual,
    input wire logic msg_ack,
    input wire logic torque_off,
    input wire logic safe_operating_stop,
    input wire logic limited_speed,
    input wire logic [15:0] speed_limit_out,
    input wire logic setpoint_zero,
    input wire logic fast_stop_ramp,
    input wire logic accel_monitor,
    input wire logic brake_ramp_monitor,
    input wire logic limit_exceeded_message,
    input wire logic [15:0] accel_ceiling
);
    logic [15:0] spd_q;
    logic [16:0] ceil_sum;
    logic [15:0] ceil_exp;

    // --------
    // Expected ceiling at monitor entry
    // --------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            spd_q <= 16'h0000;
        end else begin
            spd_q <= speed_actual;
        end
    end
    assign ceil_sum = {1'b0, spd_q} + {1'b0, cfg.accel_speed_tolerance};
    assign ceil_exp = ceil_sum[16] ? 16'hFFFF : ceil_sum[15:0];

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // --------
    // Properties
    // --------
    property p_torque_zero; torque_off |-> setpoint_zero; endproperty
    a_torque_zero: assert property (p_torque_zero) else $error("torque off without zero setpoint");
    property p_ramp_zero; fast_stop_ramp |-> setpoint_zero && !torque_off; endproperty
    a_ramp_zero: assert property (p_ramp_zero) else $error("fast stop without zero setpoint");
    property p_accel_brake; accel_monitor |-> fast_stop_ramp; endproperty
    a_accel_brake: assert property (p_accel_brake) else $error("accel monitor outside braking");
    property p_ramp_after; brake_ramp_monitor |-> fast_stop_ramp && $past(fast_stop_ramp, 2); endproperty
    a_ramp_after: assert property (p_ramp_after) else $error("ramp monitor too early");
    property p_ceil_entry; $rose(accel_monitor) |-> accel_ceiling == ceil_exp; endproperty
    a_ceil_entry: assert property (p_ceil_entry) else $error("entry ceiling wrong");
    property p_ceil_down; accel_monitor && $past(accel_monitor) |-> accel_ceiling <= $past(accel_ceiling); endproperty
    a_ceil_down: assert property (p_ceil_down) else $error("ceiling rose");
    property p_viol;
        $rose(limit_exceeded_message) |-> torque_off && !fast_stop_ramp && !accel_monitor && !brake_ramp_monitor;
    endproperty
    a_viol: assert property (p_viol) else $error("message without torque off");
    property p_msg_hold; $fell(limit_exceeded_message) |-> $past(msg_ack); endproperty
    a_msg_hold: assert property (p_msg_hold) else $error("message cleared without ack");
    property p_diag; $rose(setpoint_zero) |-> !$past(sel_from_diag); endproperty
    a_diag: assert property (p_diag) else $error("diagnostic selection taken");
    property p_direct;
        $rose(torque_off) && !$past(setpoint_zero) |-> $past(sel.failsafe_input) && cfg.controlled_stop_delay == 16'h0000;
    endproperty
    a_direct: assert property (p_direct) else $error("direct torque off without cause");
    property p_limit; limited_speed |-> speed_limit_out == cfg.new_speed_limit && !setpoint_zero; endproperty
    a_limit: assert property (p_limit) else $error("limit not adopted");
    property p_sos; $rose(safe_operating_stop) |-> $past(fast_stop_ramp) && !torque_off; endproperty
    a_sos: assert property (p_sos) else $error("safe stop not after braking");
endmodule

bind brsm_top brsm_chk #(.MC_CLKS(MC_CLKS)) u_brsm_chk (
    .clk_sys, .rst_n, .sel, .sel_from_diag, .cfg, .speed_actual, .msg_ack, .torque_off,
    .safe_operating_stop, .limited_speed, .speed_limit_out, .setpoint_zero, .fast_stop_ramp,
    .accel_monitor, .brake_ramp_monitor, .limit_exceeded_message, .accel_ceiling
);

/* tb/brsm_partner.sv */
// Far side model: failsafe controller selections and motor speed feedback.
// Assumes requests from the bench change at the falling edge of clk_sys.
`timescale 1ns/1ps

module brsm_partner (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire brsm_pkg::brsm_sel_t req_sel,
    input wire logic req_diag,
    input wire logic [15:0] req_speed,
    input wire logic [15:0] req_step,
    output brsm_pkg::brsm_sel_t sel,
    output logic sel_from_diag,
    output logic [15:0] speed_actual
);
    logic [15:0] gap;

    assign gap = (speed_actual > req_speed) ? speed_actual - req_speed : req_speed - speed_actual;
    assign sel = req_sel;
    assign sel_from_diag = req_diag;

    // Speed slews by req_step per clock, zero step jumps
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            speed_actual <= 16'h0000;
        end else begin
            if (req_step == 16'h0000 || gap <= req_step) begin
                speed_actual <= req_speed;
            end else if (speed_actual > req_speed) begin
                speed_actual <= speed_actual - req_step;
            end else begin
                speed_actual <= speed_actual + req_step;
            end
        end
    end
endmodule

/* tb/tb.sv */
// Self-checking bench of the braking ramp safety monitor.
// Assumes brsm_partner, the bound checker and a 50 clock monitoring cycle.
`timescale 1ns/1ps

module tb;
    localparam int MC = 50;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic msg_ack = 1'b0;
    logic req_diag = 1'b0;
    logic [15:0] req_speed = 16'h0000;
    logic [15:0] req_step = 16'h0000;
    brsm_pkg::brsm_sel_t req_sel = '0;
    brsm_pkg::brsm_cfg_t cfg = {16'h0010, 16'h0020, 16'h000C, 16'hFFFF, 16'hFFFF,
                                16'h0008, 16'h0000, 16'h0014, 16'h0100};
    brsm_pkg::brsm_sel_t sel;
    logic sel_from_diag;
    logic [15:0] speed_actual, speed_limit_out, accel_ceiling, spd;
    logic torque_off, safe_operating_stop, limited_speed, setpoint_zero;
    logic fast_stop_ramp, accel_monitor, brake_ramp_monitor, limit_exceeded_message;
    logic [7:0] st;
    int mismatches = 0;
    int n_tests = 0;
    int cycles = 0;
    int n0, n1, seed;

    assign st = {torque_off, safe_operating_stop, limited_speed, setpoint_zero,
                 fast_stop_ramp, accel_monitor, brake_ramp_monitor, limit_exceeded_message};

    initial begin
        forever #20 clk_sys = ~clk_sys;
    end

    brsm_partner u_partner (.clk_sys, .rst_n, .req_sel, .req_diag, .req_speed, .req_step,
                            .sel, .sel_from_diag, .speed_actual);
    brsm_top #(.MC_CLKS(MC)) dut (.clk_sys, .rst_n, .sel, .sel_from_diag, .cfg, .speed_actual, .msg_ack,
        .torque_off, .safe_operating_stop, .limited_speed, .speed_limit_out, .setpoint_zero,
        .fast_stop_ramp, .accel_monitor, .brake_ramp_monitor, .limit_exceeded_message, .accel_ceiling);

    // --------
    // Helpers
    // --------
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wait_st(input logic [7:0] mask, input logic [7:0] val, input int lim, output int n);
        n = 0;
        while ((st & mask) !== val && n < lim) begin
            @(negedge clk_sys);
            n++;
        end
    endtask

    task automatic go_idle();
        int n;
        @(negedge clk_sys);
        req_sel = '0;
        req_diag = 1'b0;
        msg_ack = 1'b1;
        wait_st(8'hFF, 8'h00, 3 * MC, n);
        msg_ack = 1'b0;
    endtask

    task automatic stop(input logic [3:0] s);
        @(negedge clk_sys);
        req_sel = s;
        wait_st(8'h08, 8'h08, 3 * MC, n0);
    endtask

    function automatic int exp_rd(input logic [15:0] ms);
        int r;
        r = (int'(ms) + 2) / 4;
        return (r < 3) ? 3 : r;
    endfunction

    task automatic finish_test();
        $display("Counts: tests=%0d mismatches=%0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            finish_test();
        end
    end

    // --------
    // Scenarios
    // --------
    initial begin
        seed = $urandom(32'h7294_f829);
        repeat (6) @(negedge clk_sys);
        rst_n = 1'b1;
        @(negedge clk_sys);
        req_sel.failsafe_input = 1'b1;
        wait_st(8'h80, 8'h80, 3 * MC, n0);
        check(24'(st), 24'h00_0090);
        go_idle();
        cfg.controlled_stop_delay = 16'h0190;
        for (int i = 0; i < 3; i++) begin
            cfg.ramp_delay_time = (i == 0) ? 16'h0004 : (i == 1) ? 16'h001E : 16'h00FA;
            spd = 16'h0100 + 16'($urandom_range(24575));
            req_speed = spd;
            stop((i == 2) ? 4'b0001 : 4'b1000);
            check(24'(st), 24'h00_001C);
            check(24'(accel_ceiling), 24'(spd + 16'h0010));
            wait_st(8'h02, 8'h02, 200 * MC, n1);
            check(24'(n1), 24'(MC * exp_rd(cfg.ramp_delay_time)));
            wait_st(8'h80, 8'h80, 200 * MC, n0);
            check(24'(n1 + n0), 24'(MC * 100));
            check(24'(st), 24'h00_0090);
            go_idle();
        end
        req_speed = 16'h0040;
        stop(4'b1000);
        req_speed = 16'h0018;
        wait_st(8'h04, 8'h00, 3 * MC, n0);
        check(24'(st), 24'h00_0018);
        req_step = 16'h0001;
        req_speed = 16'h0004;
        wait_st(8'h80, 8'h80, 5 * MC, n0);
        check(24'(st), 24'h00_0090);
        go_idle();
        req_step = 16'h0000;
        req_speed = 16'h0200;
        stop(4'b1000);
        req_speed = 16'h0210;
        repeat (3 * MC) @(negedge clk_sys);
        check(24'(st), 24'h00_001C);
        req_speed = 16'h0211;
        wait_st(8'h80, 8'h80, 2 * MC, n0);
        check(24'(st), 24'h00_0091);
        msg_ack = 1'b1;
        @(negedge clk_sys);
        check(24'(st[0]), 24'h00_0000);
        go_idle();
        cfg.ramp_delay_time = 16'h000C;
        cfg.ramp_reference_velocity = 16'h0100;
        cfg.ramp_monitor_time = 16'h0004;
        req_speed = 16'h0080;
        stop(4'b1000);
        wait_st(8'h80, 8'h80, 5 * MC, n0);
        check(24'(n0), 24'(3 * MC));
        check(24'(st), 24'h00_0091);
        go_idle();
        req_speed = 16'h0000;
        stop(4'b0100);
        wait_st(8'h40, 8'h40, 8 * MC, n0);
        check(24'(n0), 24'(5 * MC));
        check(24'(st), 24'h00_0050);
        go_idle();
        @(negedge clk_sys);
        req_sel = 4'b0010;
        wait_st(8'h20, 8'h20, 3 * MC, n0);
        check(24'(speed_limit_out), 24'h00_0100);
        go_idle();
        @(negedge clk_sys);
        req_diag = 1'b1;
        req_sel = 4'b1000;
        repeat (3 * MC) @(negedge clk_sys);
        check(24'(st), 24'h00_0000);
        go_idle();
        finish_test();
    end
endmodule
